// *** src/ipc_power_ctrl.sv ***
// Top of the inverter power control: mode choice, PID loop and drive settings.
`timescale 1ns/100ps
`include "ipc_defines.svh"
module ipc_power_ctrl (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               power_on,
	input  wire logic               cep_valid,
	input  wire logic signed [15:0] cep_error,
	output logic                    cep_abandoned,
	output logic                    leg_a,
	output logic                    leg_b,
	output logic                    full_bridge,
	output ipc_pkg::ipc_ctl_t       ctl_mode,
	output logic [17:0]             switching_frequency,
	output logic [12:0]             phase_units,
	output logic [12:0]             duty_units,
	output logic                    settings_busy
);
	localparam logic [17:0] F_MIN   = 18'(`IPC_F_MIN_HZ);
	localparam logic [17:0] F_MAX   = 18'(`IPC_F_MAX_HZ);
	localparam logic [17:0] F_XOVER = 18'(`IPC_F_XOVER_HZ);
	localparam logic [17:0] F_PING  = 18'(`IPC_F_PING_HZ);
	localparam logic [12:0] PH_MAX  = 13'(`IPC_PH_MAX);
	localparam logic [12:0] D_MIN   = 13'(`IPC_DUTY_MIN);
	localparam logic [12:0] D_MAX   = 13'(`IPC_DUTY_MAX);

	ipc_pkg::ipc_state_t st_q;
	logic signed [31:0]  integ_q;
	logic signed [31:0]  integ_d;
	logic signed [31:0]  pid_out;
	logic signed [31:0]  step;
	logic signed [31:0]  f_next;
	logic signed [31:0]  v_next;
	logic signed [15:0]  err_q;
	logic                div_start_q;
	logic                div_done;
	logic [31:0]         div_quo;
	logic [15:0]         period_q;
	logic                gate_boundary;
	logic                div_pend_q;
	logic                div_run_q;
	logic                div_go;

	function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input logic signed [31:0] lim);
		if (v > lim)
			return lim;
		else if (v < -lim)
			return -lim;
		else
			return v;
	endfunction : clamp

	// Frequency step per loop unit, in tenths of a hertz, by band.
	function automatic logic signed [31:0] freq_scale10(input logic [17:0] f);
		if (f < 18'(`IPC_F_B1_HZ))
			return 32'sd10;
		else if (f < 18'(`IPC_F_B2_HZ))
			return 32'sd15;
		else if (f < F_XOVER)
			return 32'sd20;
		else if (f < 18'(`IPC_F_B3_HZ))
			return 32'sd30;
		else
			return 32'sd50;
	endfunction : freq_scale10

	// PID with zero derivative gain; integral advances by ki times the error per packet.
	always_comb begin
		integ_d = 32'sd0;
		pid_out = 32'sd0;
		unique case (ctl_mode)
			ipc_pkg::IPC_CTL_FREQ: begin
				integ_d = clamp(integ_q + 32'(err_q) * `IPC_KI_FREQ, `IPC_INT_LIM * `IPC_GAIN_DIV);
				pid_out = clamp((32'(err_q) * `IPC_KP_FREQ + integ_d) / `IPC_GAIN_DIV, `IPC_PID_LIM);
			end
			ipc_pkg::IPC_CTL_PHASE: begin
				integ_d = clamp(integ_q + 32'(err_q) * `IPC_KI_PHASE, `IPC_INT_LIM * `IPC_GAIN_DIV);
				pid_out = clamp((32'(err_q) * `IPC_KP_PHASE + integ_d) / `IPC_GAIN_DIV, `IPC_PID_LIM);
			end
			ipc_pkg::IPC_CTL_DUTY: begin
				integ_d = clamp(integ_q + 32'(err_q) * `IPC_KI_DUTY, `IPC_INT_LIM * `IPC_GAIN_DIV);
				pid_out = clamp((32'(err_q) * `IPC_KP_DUTY + integ_d) / `IPC_GAIN_DIV, `IPC_PID_LIM);
			end
		endcase
	end

	// A positive error asks for more power: frequency and phase go down, duty goes up.
	assign step   = (ctl_mode == ipc_pkg::IPC_CTL_FREQ) ? (pid_out * freq_scale10(switching_frequency)) / 10 : pid_out;
	assign f_next = 32'(switching_frequency) - step;
	assign v_next = (ctl_mode == ipc_pkg::IPC_CTL_PHASE) ? 32'(phase_units) - pid_out
		: 32'(duty_units) + pid_out;

	// The loop iteration and the mode selection move together.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q                <= ipc_pkg::IPC_ST_IDLE;
			integ_q             <= '0;
			err_q               <= '0;
			ctl_mode            <= ipc_pkg::IPC_CTL_FREQ;
			full_bridge         <= 1'b0;
			switching_frequency <= F_PING;
			phase_units         <= '0;
			duty_units          <= D_MAX;
			cep_abandoned       <= 1'b0;
			div_start_q         <= 1'b0;
		end else begin
			cep_abandoned <= 1'b0;
			div_start_q   <= 1'b0;
			if (!power_on) begin
				st_q                <= ipc_pkg::IPC_ST_IDLE;
				integ_q             <= '0;
				ctl_mode            <= ipc_pkg::IPC_CTL_FREQ;
				full_bridge         <= 1'b0;
				switching_frequency <= F_PING;
				phase_units         <= '0;
				duty_units          <= D_MAX;
			end else begin
				unique case (st_q)
					ipc_pkg::IPC_ST_IDLE: begin
						if (cep_valid) begin
							err_q <= cep_error;
							st_q  <= ipc_pkg::IPC_ST_CALC;
						end
					end
					ipc_pkg::IPC_ST_CALC: begin
						integ_q <= integ_d;
						st_q    <= ipc_pkg::IPC_ST_APPLY;
						unique case (ctl_mode)
							ipc_pkg::IPC_CTL_FREQ: begin
								// Signed compares: a negative next value must clamp low, never wrap past the top.
								if (f_next >= $signed(32'(F_MAX))) begin
									switching_frequency <= F_MAX;
									ctl_mode            <= ipc_pkg::IPC_CTL_DUTY;
									integ_q             <= '0;
								end else if (!full_bridge && f_next <= $signed(32'(F_XOVER))) begin
									// Crossing down: the iteration stops at the crossover.
									switching_frequency <= F_XOVER;
									full_bridge         <= 1'b1;
									phase_units         <= PH_MAX;
									ctl_mode            <= ipc_pkg::IPC_CTL_PHASE;
									integ_q             <= '0;
									cep_abandoned       <= 1'b1;
								end else if (full_bridge && f_next >= $signed(32'(F_XOVER))) begin
									switching_frequency <= F_XOVER;
									ctl_mode            <= ipc_pkg::IPC_CTL_PHASE;
									phase_units         <= '0;
									integ_q             <= '0;
									cep_abandoned       <= 1'b1;
								end else if (f_next <= $signed(32'(F_MIN))) begin
									switching_frequency <= F_MIN;
								end else begin
									switching_frequency <= 18'(f_next);
								end
							end
							ipc_pkg::IPC_CTL_PHASE: begin
								if (v_next >= $signed(32'(PH_MAX))) begin
									// Rising past full phase: half-bridge at the crossover.
									full_bridge   <= 1'b0;
									phase_units   <= '0;
									duty_units    <= D_MAX;
									ctl_mode      <= ipc_pkg::IPC_CTL_FREQ;
									integ_q       <= '0;
									cep_abandoned <= 1'b1;
								end else if (v_next <= 32'sd0) begin
									phase_units <= '0;
									ctl_mode    <= ipc_pkg::IPC_CTL_FREQ;
									integ_q     <= '0;
								end else begin
									phase_units <= 13'(v_next);
								end
							end
							ipc_pkg::IPC_CTL_DUTY: begin
								if (v_next >= $signed(32'(D_MAX))) begin
									duty_units <= D_MAX;
									ctl_mode   <= ipc_pkg::IPC_CTL_FREQ;
									integ_q    <= '0;
								end else if (v_next <= $signed(32'(D_MIN))) begin
									duty_units <= D_MIN;
								end else begin
									duty_units <= 13'(v_next);
								end
							end
						endcase
					end
					ipc_pkg::IPC_ST_APPLY: begin
						div_start_q <= 1'b1;
						st_q        <= ipc_pkg::IPC_ST_IDLE;
					end
				endcase
			end
		end
	end

	assign settings_busy = (st_q != ipc_pkg::IPC_ST_IDLE);

	// A request that meets a busy divider is held, so the period always follows the last frequency.
	assign div_go = div_pend_q && !div_run_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_pend_q <= 1'b0;
			div_run_q  <= 1'b0;
		end else begin
			if (div_go)
				div_run_q <= 1'b1;
			else if (div_done)
				div_run_q <= 1'b0;
			if (div_start_q || !power_on)
				div_pend_q <= 1'b1;
			else if (div_go)
				div_pend_q <= 1'b0;
		end
	end

	ipc_divider #(
		.W(32)
	) u_div (
		.clk      (clk),
		.rst_n    (rst_n),
		.start    (div_go),
		.dividend (32'(`IPC_CLK_HZ)),
		.divisor  (32'(switching_frequency)),
		.done     (div_done),
		.quotient (div_quo)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			period_q <= 16'(`IPC_CLK_HZ / `IPC_F_PING_HZ);
		else if (div_done)
			period_q <= div_quo[15:0];
	end

	// Duty and phase are scaled from the period; resolution is bounded by the 25 ns clock.
	logic [15:0] high_cyc;
	logic [15:0] shift_cyc;
	assign high_cyc  = full_bridge ? period_q[15:1]
		: 16'((32'(period_q) * 32'(duty_units)) / 10000);
	assign shift_cyc = 16'((32'(period_q) * 32'(phase_units)) / 10000);

	ipc_gate_gen u_gate (
		.clk         (clk),
		.rst_n       (rst_n),
		.enable      (power_on),
		.full_bridge (full_bridge),
		.period_cyc  (period_q),
		.high_cyc    (high_cyc),
		.shift_cyc   (shift_cyc),
		.boundary    (gate_boundary),
		.leg_a       (leg_a),
		.leg_b       (leg_b)
	);
endmodule : ipc_power_ctrl

// *** src/ipc_defines.svh ***
// Constants for the inverter power control block.
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH
`define IPC_CLK_HZ        40000000
// Frequency held in Hz; period counts in 25 ns cycles (40 MHz / f).
`define IPC_F_MIN_HZ      110000
`define IPC_F_MAX_HZ      205000
`define IPC_F_XOVER_HZ    160000
`define IPC_F_PING_HZ     175000
`define IPC_F_B1_HZ       130000
`define IPC_F_B2_HZ       140000
`define IPC_F_B3_HZ       180000
// Phase in units of 0.036 degrees: 135 deg = 3750.
`define IPC_PH_MAX        3750
// Duty in units of 0.01 percent: 10 % = 1000, 50 % = 5000.
`define IPC_DUTY_MIN      1000
`define IPC_DUTY_MAX      5000
`define IPC_INT_LIM       3000
`define IPC_PID_LIM       20000
// Gains scaled by 100: integral 0.05 -> 5, 0.01 -> 1, 1 -> 100.
`define IPC_KP_FREQ       1000
`define IPC_KI_FREQ       5
`define IPC_KP_PHASE      100
`define IPC_KI_PHASE      1
`define IPC_KP_DUTY       1000
`define IPC_KI_DUTY       100
`define IPC_GAIN_DIV      100
`endif

// *** src/ipc_pkg.sv ***
// Types for the inverter power control block.
package ipc_pkg;
	typedef enum logic [2:0] {
		IPC_CTL_FREQ  = 3'b001,
		IPC_CTL_PHASE = 3'b010,
		IPC_CTL_DUTY  = 3'b100
	} ipc_ctl_t;
	typedef enum logic [2:0] {
		IPC_ST_IDLE = 3'b001,
		IPC_ST_CALC = 3'b010,
		IPC_ST_APPLY = 3'b100
	} ipc_state_t;
endpackage : ipc_pkg

// *** src/ipc_divider.sv ***
// Serial unsigned divider used to turn a frequency into a period count.
`timescale 1ns/100ps
module ipc_divider #(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic [W-1:0] dividend,
	input  wire logic [W-1:0] divisor,
	output logic              done,
	output logic [W-1:0]      quotient
);
	logic [W-1:0] rem_q;
	logic [W-1:0] quo_q;
	logic [W-1:0] dvd_q;
	logic [W-1:0] dvs_q;
	logic [5:0]   cnt_q;
	logic         busy_q;
	logic [W:0]   trial;

	assign trial = {rem_q, dvd_q[W-1]};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rem_q    <= '0;
			quo_q    <= '0;
			dvd_q    <= '0;
			dvs_q    <= '0;
			cnt_q    <= '0;
			busy_q   <= 1'b0;
			done     <= 1'b0;
			quotient <= '0;
		end else begin
			done <= 1'b0;
			if (start && !busy_q) begin
				rem_q  <= '0;
				quo_q  <= '0;
				dvd_q  <= dividend;
				// The divisor is held for the whole run, so a frequency change mid-run cannot corrupt the quotient.
				dvs_q  <= divisor;
				cnt_q  <= 6'(W);
				busy_q <= 1'b1;
			end else if (busy_q) begin
				dvd_q <= dvd_q << 1;
				if (trial >= {1'b0, dvs_q}) begin
					rem_q <= W'(trial - {1'b0, dvs_q});
					quo_q <= {quo_q[W-2:0], 1'b1};
				end else begin
					rem_q <= trial[W-1:0];
					quo_q <= {quo_q[W-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 6'h01;
				if (cnt_q == 6'h01) begin
					busy_q   <= 1'b0;
					done     <= 1'b1;
					quotient <= (trial >= {1'b0, dvs_q}) ? {quo_q[W-2:0], 1'b1} : {quo_q[W-2:0], 1'b0};
				end
			end
		end
	end
endmodule : ipc_divider

// *** src/ipc_gate_gen.sv ***
// Gate pulse generator for the half-bridge and full-bridge legs.
`timescale 1ns/100ps
module ipc_gate_gen (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        enable,
	input  wire logic        full_bridge,
	input  wire logic [15:0] period_cyc,
	input  wire logic [15:0] high_cyc,
	input  wire logic [15:0] shift_cyc,
	output logic             boundary,
	output logic             leg_a,
	output logic             leg_b
);
	logic [15:0] cnt_q;
	logic [15:0] per_q;
	logic [15:0] high_q;
	logic [15:0] shift_q;
	logic        fb_q;
	logic [16:0] half_end;
	logic [16:0] b_start;

	assign boundary = enable && (cnt_q >= per_q - 16'h0001);
	assign half_end = {1'b0, shift_q} + {2'b00, per_q[15:1]};
	assign b_start  = {1'b0, shift_q};

	// Settings are latched when the period wraps or while disabled, so no gate pulse is cut short.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q   <= '0;
			per_q   <= 16'h00e4;
			high_q  <= 16'h0072;
			shift_q <= '0;
			fb_q    <= 1'b0;
		end else if (!enable) begin
			cnt_q   <= '0;
			per_q   <= period_cyc;
			high_q  <= high_cyc;
			shift_q <= shift_cyc;
			fb_q    <= full_bridge;
		end else if (boundary) begin
			cnt_q   <= '0;
			per_q   <= period_cyc;
			high_q  <= high_cyc;
			shift_q <= shift_cyc;
			fb_q    <= full_bridge;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			leg_a <= 1'b0;
			leg_b <= 1'b0;
		end else if (!enable) begin
			leg_a <= 1'b0;
			leg_b <= 1'b0;
		end else begin
			leg_a <= (cnt_q < high_q);
			if (fb_q)
				leg_b <= ({1'b0, cnt_q} >= b_start) ? ({1'b0, cnt_q} < half_end)
					: ({1'b0, cnt_q} + {1'b0, per_q} < half_end);
			else
				leg_b <= 1'b0;
		end
	end
endmodule : ipc_gate_gen

// *** tb/ipc_props.sv ***
// Port-level assertions for the inverter power control top.
`timescale 1ns/100ps
module ipc_props (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               power_on,
	input wire logic               cep_valid,
	input wire logic signed [15:0] cep_error,
	input wire logic               cep_abandoned,
	input wire logic               leg_a,
	input wire logic               leg_b,
	input wire logic               full_bridge,
	input ipc_pkg::ipc_ctl_t       ctl_mode,
	input wire logic [17:0]        switching_frequency,
	input wire logic [12:0]        phase_units,
	input wire logic [12:0]        duty_units,
	input wire logic               settings_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_freq_range;
		switching_frequency >= 18'h1adb0 && switching_frequency <= 18'h320c8;
	endproperty
	a_freq_range: assert property (p_freq_range) else $error("frequency out of range");
	property p_phase_range;
		phase_units <= 13'h0ea6;
	endproperty
	a_phase_range: assert property (p_phase_range) else $error("phase out of range");
	property p_duty_range;
		duty_units >= 13'h03e8 && duty_units <= 13'h1388;
	endproperty
	a_duty_range: assert property (p_duty_range) else $error("duty out of range");
	property p_duty_mode;
		ctl_mode == ipc_pkg::IPC_CTL_DUTY |-> !full_bridge && switching_frequency == 18'h320c8;
	endproperty
	a_duty_mode: assert property (p_duty_mode) else $error("duty control off the ceiling");
	property p_freq_half;
		ctl_mode == ipc_pkg::IPC_CTL_FREQ && !full_bridge |-> duty_units == 13'h1388 && switching_frequency >= 18'h27100;
	endproperty
	a_freq_half: assert property (p_freq_half) else $error("half bridge frequency control wrong");
	property p_phase_mode;
		ctl_mode == ipc_pkg::IPC_CTL_PHASE |-> full_bridge && switching_frequency == 18'h27100;
	endproperty
	a_phase_mode: assert property (p_phase_mode) else $error("phase control off the crossover");
	property p_freq_full;
		ctl_mode == ipc_pkg::IPC_CTL_FREQ && full_bridge |-> phase_units == 13'h0000 && switching_frequency <= 18'h27100;
	endproperty
	a_freq_full: assert property (p_freq_full) else $error("full bridge frequency control wrong");
	property p_abandon;
		cep_abandoned |-> switching_frequency == 18'h27100 ##1 !cep_abandoned;
	endproperty
	a_abandon: assert property (p_abandon) else $error("abandon pulse wrong");
	property p_busy;
		cep_valid && !settings_busy && power_on |=> settings_busy ##2 !settings_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("packet handling time wrong");
	property p_dir;
		cep_valid && !settings_busy && power_on && cep_error > 16'sh0000 && ctl_mode == ipc_pkg::IPC_CTL_FREQ
			|-> ##3 switching_frequency <= $past(switching_frequency, 3);
	endproperty
	a_dir: assert property (p_dir) else $error("more power asked but frequency rose");
endmodule : ipc_props
bind ipc_power_ctrl ipc_props u_props (.clk(clk), .rst_n(rst_n), .power_on(power_on), .cep_valid(cep_valid),
	.cep_error(cep_error), .cep_abandoned(cep_abandoned), .leg_a(leg_a), .leg_b(leg_b),
	.full_bridge(full_bridge), .ctl_mode(ctl_mode), .switching_frequency(switching_frequency),
	.phase_units(phase_units), .duty_units(duty_units), .settings_busy(settings_busy));

// *** tb/ipc_inverter_model.sv ***
// Behavioural inverter stage that measures the gate period it is driven with.
`timescale 1ns/100ps
module ipc_inverter_model (
	input  wire logic   clk,
	input  wire logic   rst_n,
	input  wire logic   leg_a,
	output logic [15:0] period_seen
);
	logic [15:0] count_q;
	logic        leg_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= 16'h0000;
			leg_q <= 1'b0;
			period_seen <= 16'h0000;
		end else begin
			leg_q <= leg_a;
			if (leg_a && !leg_q) begin
				period_seen <= count_q + 16'h0001;
				count_q <= 16'h0000;
			end else begin
				count_q <= count_q + 16'h0001;
			end
		end
	end
endmodule : ipc_inverter_model

// *** tb/inverter_power_control_tb.sv ***
// Self-checking bench for the inverter power control top.
`timescale 1ns/100ps
module inverter_power_control_tb;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               power_on = 1'b0;
	logic               cep_valid = 1'b0;
	logic signed [15:0] cep_error = 16'sh0000;
	logic               cep_abandoned, leg_a, leg_b, full_bridge, settings_busy;
	ipc_pkg::ipc_ctl_t  ctl_mode;
	logic [17:0]        switching_frequency, f0;
	logic [12:0]        phase_units, duty_units;
	logic [15:0]        period_seen;
	logic [31:0]        rng = 32'h0000d68a;
	logic               abandon_seen = 1'b0;
	int                 fail_count = 0;
	int                 n_compared = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) if (cep_abandoned === 1'b1) abandon_seen <= 1'b1;
	ipc_power_ctrl uut (.clk(clk), .rst_n(rst_n), .power_on(power_on), .cep_valid(cep_valid),
		.cep_error(cep_error), .cep_abandoned(cep_abandoned), .leg_a(leg_a), .leg_b(leg_b),
		.full_bridge(full_bridge), .ctl_mode(ctl_mode), .switching_frequency(switching_frequency),
		.phase_units(phase_units), .duty_units(duty_units), .settings_busy(settings_busy));
	ipc_inverter_model u_inv (.clk(clk), .rst_n(rst_n), .leg_a(leg_a), .period_seen(period_seen));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic send(input logic signed [15:0] err);
		int n;
		n = 0;
		while (settings_busy !== 1'b0 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 50) begin
			fail_count++;
			stop_test();
		end
		cep_error = err;
		cep_valid = 1'b1;
		@(posedge clk);
		#1;
		cep_valid = 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : send
	// Random packet magnitudes push the loop until the wanted drive mode is reached.
	task automatic steer(input bit more, input ipc_pkg::ipc_ctl_t want, input logic want_fb);
		int k;
		logic [15:0] m;
		for (k = 0; k < 60 && !(ctl_mode === want && full_bridge === want_fb); k++) begin
			rng = xorshift(rng);
			m = {5'h00, rng[10:0]} + 16'h0001;
			send(more ? m : -m);
		end
		if (k == 60) begin
			fail_count++;
			stop_test();
		end
	endtask : steer
	// The gate period settles after the recompute, one old period and one full new period.
	// Both legs are then counted over exactly one period: leg a half high at 50 percent, leg b half high in full bridge and low in half bridge.
	task automatic check_period();
		logic [15:0] e;
		int          i;
		int          na;
		int          nb;
		na = 0;
		nb = 0;
		repeat (1200) @(posedge clk);
		#1;
		e = 16'(32'h02625a00 / {14'h0000, switching_frequency});
		check("period", 32'(period_seen + 16'h0001 >= e && period_seen <= e + 16'h0001), 32'h1);
		for (i = 0; i < int'(e); i++) begin
			@(posedge clk);
			#1;
			if (leg_a === 1'b1) na++;
			if (leg_b === 1'b1) nb++;
		end
		check("leg a high", 32'(na), 32'(e >> 1));
		check("leg b high", 32'(nb), full_bridge ? 32'(e >> 1) : 32'h0);
	endtask : check_period
	task automatic check_ping();
		check("ping freq", 32'(switching_frequency), 32'h0002ab98);
		check("ping duty", 32'(duty_units), 32'h00001388);
		check("ping bridge", 32'(full_bridge), 32'h0);
		check("ping mode", 32'(ctl_mode), 32'(ipc_pkg::IPC_CTL_FREQ));
	endtask : check_ping
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check_ping();
		power_on = 1'b1;
		check_period();
		f0 = switching_frequency;
		send(16'sh0001);
		check("small step", 32'(f0 - switching_frequency >= 18'h0001e && f0 - switching_frequency <= 18'h00415), 32'h1);
		f0 = switching_frequency;
		send(-16'sh0001);
		check("less power raises freq", 32'(switching_frequency > f0), 32'h1);
		steer(1'b1, ipc_pkg::IPC_CTL_PHASE, 1'b1);
		check("xover abandon", 32'(abandon_seen), 32'h1);
		check("xover phase", 32'(phase_units), 32'h00000ea6);
		check("xover freq", 32'(switching_frequency), 32'h00027100);
		steer(1'b1, ipc_pkg::IPC_CTL_FREQ, 1'b1);
		send(16'sh0400);
		check("below xover freq", 32'(switching_frequency < 18'h27100), 32'h1);
		check("below xover phase", 32'(phase_units), 32'h0);
		check_period();
		steer(1'b0, ipc_pkg::IPC_CTL_PHASE, 1'b1);
		check("rise to xover", 32'(switching_frequency), 32'h00027100);
		steer(1'b0, ipc_pkg::IPC_CTL_FREQ, 1'b0);
		check("back to half duty", 32'(duty_units), 32'h00001388);
		check("back to half freq", 32'(switching_frequency), 32'h00027100);
		steer(1'b0, ipc_pkg::IPC_CTL_DUTY, 1'b0);
		check("ceiling freq", 32'(switching_frequency), 32'h000320c8);
		send(-16'sh0010);
		check("duty cut", 32'(duty_units < 13'h1388), 32'h1);
		steer(1'b1, ipc_pkg::IPC_CTL_FREQ, 1'b0);
		check("duty restored", 32'(duty_units), 32'h00001388);
		check_period();
		power_on = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check_ping();
		check("legs off", 32'({leg_a, leg_b}), 32'h0);
		stop_test();
	end
endmodule : inverter_power_control_tb
